/* File: design/gch_pkg.sv */
// Package of constants and carrier types for the general call handler
package gch_pkg;
  localparam logic [6:0] GC_ADDR       = 7'h00;   // General call address
  localparam logic [7:0] GC_RESET      = 8'h06;   // Reset code
  localparam logic [7:0] GC_WAKE       = 8'h0a;   // Wake-up code
  localparam logic [1:0] PD_AWAKE      = 2'h0;    // Normal operation code
  localparam int         ADDR_W        = 5;       // Register address width
  localparam int         LOAD_CYCLES   = 8;       // Cycles for nonvolatile reload
  localparam logic [6:0] SLAVE_ADDR_RST = 7'h60;  // Own address after reset

  // Byte-level events from the bit engine
  typedef struct packed {
    logic       start;     // Start or repeated start seen
    logic       stop;      // Stop seen
    logic       byte_done; // Byte complete, ack slot follows
    logic [7:0] data;      // Received byte
  } gch_bus_ev_t;

  // Controller states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_GC2, ST_IGNORE, ST_NACK, ST_OWN, ST_LOAD
  } gch_state_t;
endpackage : gch_pkg

/* File: design/gch_general_call.sv */
// General call handler of the serial slave interface
// Notes on behaviour
// - Acknowledge general call address besides own address
// - Second byte alone selects general call function
// - Odd second byte: ignore all until stop
// - Code 06h acknowledged, starts internal reset
// - Reset like power-on, without delay timer
// - Reset reloads channel registers from store
// - Output valid only after reset completes
// - Code 0Ah acknowledged, clears power-down selects
// - Codes 04h and 00h are not acknowledged
// - After error, not-acknowledge until next start
// - Read after error uses last valid address
`timescale 1ns/100ps
`default_nettype none
module gch_general_call #(
  parameter int CHANNELS = 2,                     // Output channels
  parameter int DATA_W   = 12                     // Channel register width
) (
  // Clock and reset
  input  wire  logic                    clk_sys,
  input  wire  logic                    srst,
  // Byte events from bus engine
  input  wire  gch_pkg::gch_bus_ev_t    bus_ev,
  input  wire  logic                    cmd_error,    // Addressed command found invalid
  input  wire  logic                    addr_load,    // Addressed write loaded a valid address
  input  wire  logic [gch_pkg::ADDR_W-1:0] addr_in,
  // Nonvolatile store contents
  input  wire  logic [CHANNELS*DATA_W-1:0] store_data,
  // Power-down selects written by the addressed command path
  input  wire  logic                    pd_write,     // Load new power-down selects this cycle
  input  wire  logic [CHANNELS*2-1:0]   pd_in,        // New power-down selects, two bits a channel
  // Answers
  output logic                          ack,          // Drive ack in current slot
  output logic                          own_active,   // Own address transaction in progress
  output logic [gch_pkg::ADDR_W-1:0]    read_addr,    // Address used for reads
  output logic [CHANNELS*DATA_W-1:0]    dac_regs,
  output logic [CHANNELS*2-1:0]         channel_power_down_select,
  output logic                          out_valid,
  output logic                          reset_busy
);
  // Whole state of the handler, registered as one word
  typedef struct packed {
    gch_pkg::gch_state_t          st;     // Controller state
    logic [3:0]                   cnt;    // Reload cycle counter
    logic                         ack;    // Acknowledge for the current slot
    logic                         hold;   // Hardware call seen, deaf until stop
    logic [gch_pkg::ADDR_W-1:0]   addr;   // Last valid register address
    logic [CHANNELS*DATA_W-1:0]   regs;   // Channel output registers
    logic [CHANNELS*2-1:0]        pd;     // Power-down selects, two bits a channel
    logic                         valid;  // Output valid after reload
  } gch_state_s_t;

  gch_state_s_t s_reg;   // Registered state
  gch_state_s_t s_next;  // Next state

  // Next state logic; one priority chain per cycle
  always_comb begin
    // Hold everything by default; ack lasts one cycle
    s_next = s_reg;
    s_next.ack = 1'b0;
    // Power-down selects from addressed writes; general calls below override
    if (pd_write && s_reg.st != gch_pkg::ST_LOAD) begin
      s_next.pd = pd_in;
    end
    // Reload, then bus conditions, then error, then bytes
    if (s_reg.st == gch_pkg::ST_LOAD) begin
      // Reload in progress; bus ignored
      if (s_reg.cnt == 4'(gch_pkg::LOAD_CYCLES - 1)) begin
        s_next.regs  = store_data;
        s_next.valid = 1'b1;
        s_next.st    = gch_pkg::ST_IDLE;
      end else begin
        // No delay timer: count straight through the reload
        s_next.cnt = s_reg.cnt + 4'h1;
      end
    end else if (bus_ev.stop) begin
      // Stop ends every transfer and the hardware call hold
      s_next.st   = gch_pkg::ST_IDLE;
      s_next.hold = 1'b0;
    end else if (s_reg.hold) begin
      // Hardware call: repeated starts and bytes alike are ignored
      s_next.st = gch_pkg::ST_IGNORE;
    end else if (bus_ev.start) begin
      // Start leaves error and ignore states alike
      s_next.st = gch_pkg::ST_ADDR;
    end else if (cmd_error && s_reg.st == gch_pkg::ST_OWN) begin
      s_next.st = gch_pkg::ST_NACK;
    end else if (bus_ev.byte_done) begin
      case (s_reg.st)
        gch_pkg::ST_ADDR: begin
          // General call address, write direction only
          if (bus_ev.data[7:1] == gch_pkg::GC_ADDR && !bus_ev.data[0]) begin
            s_next.ack = 1'b1;
            s_next.st  = gch_pkg::ST_GC2;
          end else if (bus_ev.data[7:1] == gch_pkg::SLAVE_ADDR_RST) begin
            // Own address: ordinary command follows
            s_next.ack = 1'b1;
            s_next.st  = gch_pkg::ST_OWN;
          end else begin
            // Another device's transfer
            s_next.st = gch_pkg::ST_IGNORE;
          end
        end
        gch_pkg::ST_GC2: begin
          // Second byte decides the function
          if (bus_ev.data[0]) begin
            // Hardware call: no ack, deaf until stop
            s_next.st   = gch_pkg::ST_IGNORE;
            s_next.hold = 1'b1;
          end else if (bus_ev.data == gch_pkg::GC_RESET) begin
            // Reset: reload as at power-up, no delay timer
            s_next.ack   = 1'b1;
            s_next.st    = gch_pkg::ST_LOAD;
            s_next.cnt   = 4'h0;
            s_next.valid = 1'b0;
            s_next.pd    = '0;
          end else if (bus_ev.data == gch_pkg::GC_WAKE) begin
            // Wake-up: every channel leaves power-down
            s_next.ack = 1'b1;
            for (int i = 0; i < CHANNELS; i++) begin
              s_next.pd[i*2 +: 2] = gch_pkg::PD_AWAKE;
            end
            s_next.st = gch_pkg::ST_IGNORE;
          end else begin
            // Unsupported codes, 04h and 00h among them
            s_next.st = gch_pkg::ST_NACK;
          end
        end
        // Own transfer: every byte acknowledged
        gch_pkg::ST_OWN: s_next.ack = 1'b1;
        // Error: not acknowledged until the next start
        gch_pkg::ST_NACK: s_next.ack = 1'b0;
        // Idle and ignore: bytes pass unanswered
        default: s_next.ack = 1'b0;
      endcase
    end
    // Valid address tracking only outside error state
    if (addr_load && s_reg.st == gch_pkg::ST_OWN && !cmd_error) begin
      s_next.addr = addr_in;
    end
  end

  // State register; reset enters the reload as at power-up
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      // Everything cleared, then the reload runs after release
      s_reg       <= '0;
      s_reg.st    <= gch_pkg::ST_LOAD;
      s_reg.cnt   <= 4'h0;
      s_reg.valid <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs
  assign ack                       = s_reg.ack;
  assign own_active                = (s_reg.st == gch_pkg::ST_OWN);
  // Data outputs straight from flip-flops
  assign read_addr                 = s_reg.addr;
  assign dac_regs                  = s_reg.regs;
  assign channel_power_down_select = s_reg.pd;
  assign out_valid                 = s_reg.valid;
  assign reset_busy                = (s_reg.st == gch_pkg::ST_LOAD);

  // Checks
  gc_addr_ack_a: assert property (@(posedge clk_sys) disable iff (srst)
    (bus_ev.byte_done && !bus_ev.start && !bus_ev.stop && !cmd_error && s_reg.st == gch_pkg::ST_ADDR
     && bus_ev.data == 8'h00) |=> ack && s_reg.st == gch_pkg::ST_GC2)
    else $error("General call address not acknowledged");
  gc_reset_go_a: assert property (@(posedge clk_sys) disable iff (srst)
    (bus_ev.byte_done && !bus_ev.start && !bus_ev.stop && s_reg.st == gch_pkg::ST_GC2
     && bus_ev.data == 8'h06) |=> ack && reset_busy && !out_valid)
    else $error("Reset code not handled");
  reload_done_a: assert property (@(posedge clk_sys) disable iff (srst)
    $fell(reset_busy) |-> out_valid && dac_regs == $past(store_data))
    else $error("Registers not reloaded");
  reset_len_a: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(reset_busy) |-> reset_busy [*8] ##1 !reset_busy)
    else $error("Reset length wrong");
  valid_late_a: assert property (@(posedge clk_sys) disable iff (srst)
    reset_busy |-> !out_valid)
    else $error("Output valid during reset");
  wake_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
    (bus_ev.byte_done && !bus_ev.start && !bus_ev.stop && s_reg.st == gch_pkg::ST_GC2
     && bus_ev.data == 8'h0a) |=> ack && channel_power_down_select == '0)
    else $error("Wake-up did not clear power-down");
  bad_code_a: assert property (@(posedge clk_sys) disable iff (srst)
    (bus_ev.byte_done && !bus_ev.start && !bus_ev.stop && s_reg.st == gch_pkg::ST_GC2
     && (bus_ev.data == 8'h04 || bus_ev.data == 8'h00)) |=> !ack)
    else $error("Unsupported code acknowledged");
  hw_call_a: assert property (@(posedge clk_sys) disable iff (srst)
    (s_reg.st == gch_pkg::ST_IGNORE && !bus_ev.stop && !bus_ev.start) |=> !ack)
    else $error("Hardware call byte acknowledged");
  err_nack_a: assert property (@(posedge clk_sys) disable iff (srst)
    (s_reg.st == gch_pkg::ST_NACK && !bus_ev.start) |=> !ack)
    else $error("Acknowledge after error");
  idle_after_a: assert property (@(posedge clk_sys) disable iff (srst)
    $fell(reset_busy) |-> s_reg.st == gch_pkg::ST_IDLE)
    else $error("Not idle after reset");
  own_addr_ack_a: assert property (@(posedge clk_sys) disable iff (srst)
    (bus_ev.byte_done && !bus_ev.start && !bus_ev.stop && s_reg.st == gch_pkg::ST_ADDR
     && bus_ev.data[7:1] == gch_pkg::SLAVE_ADDR_RST) |=> ack && own_active)
    else $error("Own address not acknowledged");
  hw_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    (s_reg.hold && !bus_ev.stop) |=> !ack && s_reg.st == gch_pkg::ST_IGNORE)
    else $error("Hardware call hold broken");
  err_enter_a: assert property (@(posedge clk_sys) disable iff (srst)
    (cmd_error && own_active && !bus_ev.start && !bus_ev.stop) |=> s_reg.st == gch_pkg::ST_NACK && !ack)
    else $error("Command error not latched");
  addr_keep_a: assert property (@(posedge clk_sys) disable iff (srst)
    cmd_error |=> $stable(read_addr))
    else $error("Address taken during command error");
  busy_deaf_a: assert property (@(posedge clk_sys) disable iff (srst)
    reset_busy |=> !ack)
    else $error("Acknowledge during reload");

  // Main scenarios reached
  cov_reset_c: cover property (@(posedge clk_sys) $fell(reset_busy) && !$past(srst));
  cov_wake_c: cover property (@(posedge clk_sys) $fell(|channel_power_down_select));
  cov_err_c: cover property (@(posedge clk_sys) s_reg.st == gch_pkg::ST_NACK);
  cov_hold_c: cover property (@(posedge clk_sys) s_reg.hold && bus_ev.start);
endmodule : gch_general_call
`default_nettype wire

/* File: tb/gch_master_model.sv */
// Bus master model driving byte-level events
`timescale 1ns/100ps
`default_nettype none
module gch_master_model (
  // Clock and device answer
  input  wire logic           clk_sys,
  input  wire logic           ack,
  // Events toward the device
  output var  gch_pkg::gch_bus_ev_t bus_ev
);
  // Quiet bus at time zero
  initial bus_ev = '{start: 1'b0, stop: 1'b0, byte_done: 1'b0, data: 8'hff};
  // One-cycle start or stop pulse
  task automatic cond(input logic is_stop);
    @(negedge clk_sys);
    bus_ev.start = !is_stop;
    bus_ev.stop  = is_stop;
    @(negedge clk_sys);
    bus_ev.start = 1'b0;
    bus_ev.stop  = 1'b0;
  endtask : cond
  // Byte for one cycle, then ack sampled at the next falling edge
  task automatic put_byte(input logic [7:0] b, output logic a);
    @(negedge clk_sys);
    bus_ev.byte_done = 1'b1;
    bus_ev.data      = b;
    @(negedge clk_sys);
    a                = ack;
    bus_ev.byte_done = 1'b0;
    bus_ev.data      = ~b;
  endtask : put_byte
endmodule : gch_master_model
`default_nettype wire

/* File: tb/gch_general_call_tb.sv */
// Self-checking bench for the general call handler
`timescale 1ns/100ps
`default_nettype none
module gch_general_call_tb;
  logic        clk_sys = 1'b0, srst, cmd_error, addr_load, pd_write, a;
  logic [4:0]  addr_in;
  logic [3:0]  pd_in;
  logic [23:0] store_data;
  logic        ack, own_active, out_valid, reset_busy;
  logic [4:0]  read_addr;
  logic [23:0] dac_regs;
  logic [3:0]  channel_power_down_select;
  gch_pkg::gch_bus_ev_t bus_ev;
  int          mismatches = 0, n_compared = 0, k;
  // Clock, 100 ns period
  initial forever #50 clk_sys = ~clk_sys;
  gch_master_model m (.clk_sys(clk_sys), .ack(ack), .bus_ev(bus_ev));
  gch_general_call DUT (.clk_sys(clk_sys), .srst(srst), .bus_ev(bus_ev), .cmd_error(cmd_error),
    .addr_load(addr_load), .addr_in(addr_in), .store_data(store_data), .pd_write(pd_write),
    .pd_in(pd_in), .ack(ack),
    .own_active(own_active), .read_addr(read_addr), .dac_regs(dac_regs),
    .channel_power_down_select(channel_power_down_select), .out_valid(out_valid), .reset_busy(reset_busy));
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  // Bounded wait for reload end, counts cycles
  task automatic wait_ready;
    for (k = 0; k < 40 && out_valid !== 1'b1; k++) @(negedge clk_sys);
  endtask : wait_ready
  // General call then second byte, returns its ack
  task automatic gc(input logic [7:0] code);
    m.cond(1'b0);
    m.put_byte(8'h00, a);
    check(a, 1, "gc address ack");
    m.put_byte(code, a);
  endtask : gc
  task automatic t_reset;
    store_data = 24'h1234ab;
    gc(gch_pkg::GC_RESET);
    check(a, 1, "reset ack");
    check(reset_busy, 1, "reload started");
    check(out_valid, 0, "output held");
    wait_ready();
    check(k <= gch_pkg::LOAD_CYCLES, 1, "no delay timer");
    check(dac_regs, 24'h1234ab, "reloaded regs");
    check(own_active, 0, "idle after reset");
  endtask : t_reset
  task automatic t_wake_and_refused;
    @(negedge clk_sys) {pd_write, pd_in} = {1'b1, 4'hb};
    @(negedge clk_sys) pd_write = 1'b0;
    check(channel_power_down_select, 4'hb, "power-down set");
    gc(gch_pkg::GC_WAKE);
    check(a, 1, "wake ack");
    check(channel_power_down_select, 4'h0, "awake");
    m.cond(1'b1);
    for (int i = 0; i < 2; i++) begin
      gc(i ? 8'h00 : 8'h04);
      check(a, 0, "unsupported nack");
      m.cond(1'b1);
    end
  endtask : t_wake_and_refused
  task automatic t_hw_call;
    gc(8'h07);
    check(a, 0, "hardware call ignored");
    m.put_byte(gch_pkg::GC_RESET, a);
    check({a, reset_busy}, 0, "later bytes ignored");
    m.cond(1'b0);
    m.put_byte(8'h00, a);
    check(a, 0, "deaf across repeated start");
    m.cond(1'b1);
  endtask : t_hw_call
  task automatic t_cmd_error;
    m.cond(1'b0);
    m.put_byte({gch_pkg::SLAVE_ADDR_RST, 1'b0}, a);
    check({a, own_active}, 2'h3, "own address");
    @(negedge clk_sys) {addr_load, addr_in} = {1'b1, 5'h09};
    @(negedge clk_sys) {cmd_error, addr_in} = {1'b1, 5'h1f};
    @(negedge clk_sys) {addr_load, cmd_error} = 2'h0;
    m.put_byte(8'h12, a);
    check(a, 0, "nack after error");
    check(read_addr, 5'h09, "last valid address");
    gc(gch_pkg::GC_WAKE);
    check(a, 1, "start clears error");
    m.cond(1'b1);
  endtask : t_cmd_error
  // Verdict and end of run
  task automatic wrap_up;
    $display("mismatches %0d, compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  // Main sequence
  initial begin
    // Inputs quiet, reset held from time zero
    {srst, cmd_error, addr_load, pd_write} = 4'h8;
    {addr_in, pd_in, store_data} = {5'h00, 4'h0, 24'h5a3c96};
    repeat (6) @(negedge clk_sys);
    srst = 1'b0;
    wait_ready();
    check(dac_regs, 24'h5a3c96, "power-up reload");
    t_reset();
    t_wake_and_refused();
    t_hw_call();
    t_cmd_error();
    wrap_up();
  end
  // Watchdog
  initial begin
    repeat (3000) @(posedge clk_sys);
    mismatches++;
    wrap_up();
  end
endmodule : gch_general_call_tb
`default_nettype wire
